// >>> hdl/sfdpc_dev.sv
// Purpose: device end: addressing mode, bank, soft reset, status reg 1
// Assumes: host keeps the link protocol; srst stands for power-up
// Notes:   reply bytes follow the byte that requests them by one cycle; parameter bytes by two
// Notes on behaviour
// - b7 enters 4-byte mode, no write enable
// - bank register read by 16h, written 17h
// - bank msb 0: 3-byte, bank selects segment
// - dedicated 4-byte opcodes always take 4 bytes
// - 66h then 99h performs soft reset
// - reset pair accepted on 1, 2, 4 lanes
// - power-up loads sr1 from non-volatile copy
// - non-volatile sr1 write needs 06h first
// - 50h enables and activates volatile sr1
// - parameter word reads A1_F8_60_E8 with fields
// - relative byte 3Ch returns E8h
module sfdpc_dev
(
  input  wire logic   clk,        // system clock
  input  wire logic   srst,       // sync reset, acts as power-up
  sfdpc_if.dev        lnk,        // command link
  input  wire logic [1:0] mode_lanes, // current interface width
  output logic        addr4_mode, // 4-byte addressing active
  output logic [7:0]  bank,       // bank register
  output logic [7:0]  sr1,        // active status register 1
  output logic [7:0]  sr1_nv,     // non-volatile copy
  output logic        sr1_vol,    // volatile copy active
  output logic        addr_vld,   // address captured pulse
  output logic [31:0] addr_full,  // resolved array address
  output logic        rst_pulse   // soft reset performed
);
  typedef enum {S_IDLE, S_OP, S_ADDR, S_DATA, S_DONE} sfdpc_st_t;

  sfdpc_st_t   st_reg, st_next;
  logic [7:0]  op_reg, op_next;
  logic [2:0]  cnt_reg, cnt_next;
  logic [31:0] adr_reg, adr_next;
  logic        a4_reg, a4_next;
  logic [7:0]  bank_reg, bank_next;
  logic [7:0]  nv_reg, nv_next;
  logic [7:0]  vsr_reg, vsr_next;
  logic        vact_reg, vact_next;
  logic        wel_reg, wel_next;
  logic        vwel_reg, vwel_next;
  logic        ren_reg, ren_next;
  logic        rv_reg, rv_next;
  logic [7:0]  rb_reg, rb_next;
  logic        av_reg, av_next;
  logic [31:0] af_reg, af_next;
  logic        rp_reg, rp_next;
  logic [7:0]  pidx_reg, pidx_next;
  logic        lanes_ok;
  logic        is4;
  logic [2:0]  alen;
  logic        fb;

  assign fb       = lnk.h_valid && !lnk.cs_n;
  assign lanes_ok = (lnk.h_lanes == mode_lanes);
  assign is4      = op_reg[sfdpc_pkg::OP4_FLAG_BIT];
  assign alen     = (is4 || a4_reg) ? 3'd4 : 3'd3;

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb
  begin
    st_next   = st_reg;
    op_next   = op_reg;
    cnt_next  = cnt_reg;
    adr_next  = adr_reg;
    a4_next   = a4_reg;
    bank_next = bank_reg;
    nv_next   = nv_reg;
    vsr_next  = vsr_reg;
    vact_next = vact_reg;
    wel_next  = wel_reg;
    vwel_next = vwel_reg;
    ren_next  = ren_reg;
    rv_next   = 1'b0;
    rb_next   = rb_reg;
    av_next   = 1'b0;
    af_next   = af_reg;
    rp_next   = 1'b0;
    pidx_next = pidx_reg;
    case (st_reg)
      S_IDLE:
      begin
        if (fb && lanes_ok)
        begin
          op_next  = lnk.h_byte;
          cnt_next = 3'd0;
          adr_next = 32'h0000_0000;
          st_next  = S_OP;
          // arming survives only into the very next command
          ren_next = (lnk.h_byte == sfdpc_pkg::OP_RST_EN);
          case (lnk.h_byte)
            sfdpc_pkg::OP_ENTER4:  a4_next = 1'b1;
            sfdpc_pkg::OP_WREN:    wel_next = 1'b1;
            sfdpc_pkg::OP_VWREN:
            begin
              vwel_next = 1'b1;
              vact_next = 1'b1;
              vsr_next  = nv_reg;
            end
            sfdpc_pkg::OP_RST:
            begin
              if (ren_reg)
              begin
                rp_next   = 1'b1;
                a4_next   = 1'b0;
                bank_next = sfdpc_pkg::BANK_RST;
                wel_next  = 1'b0;
                vwel_next = 1'b0;
                vact_next = 1'b0;
              end
            end
            sfdpc_pkg::OP_BANK_RD:
            begin
              rv_next = 1'b1;
              rb_next = bank_reg;
            end
            sfdpc_pkg::OP_SR1_RD:
            begin
              rv_next = 1'b1;
              rb_next = vact_reg ? vsr_reg : nv_reg;
            end
            default: ;
          endcase
        end
        // wrong width: later bytes must not pass for opcodes
        else if (fb)
          st_next = S_DONE;
      end
      S_OP:
      begin
        if (lnk.cs_n)
          st_next = S_IDLE;
        else if (fb)
        begin
          case (op_reg)
            sfdpc_pkg::OP_BANK_WR:
            begin
              bank_next = lnk.h_byte;
              st_next   = S_DONE;
            end
            sfdpc_pkg::OP_SR1_WR:
            begin
              if (vwel_reg)
              begin
                vsr_next  = lnk.h_byte;
                vwel_next = 1'b0;
              end
              else if (wel_reg)
              begin
                nv_next  = lnk.h_byte;
                wel_next = 1'b0;
              end
              st_next = S_DONE;
            end
            sfdpc_pkg::OP_PARAM_RD:
            begin
              pidx_next = lnk.h_byte - sfdpc_pkg::PARAM_BASE;
              st_next   = S_DATA;
            end
            sfdpc_pkg::OP_READ3, sfdpc_pkg::OP_PROG3,
            sfdpc_pkg::OP_READ4, sfdpc_pkg::OP_PROG4:
            begin
              adr_next = {24'h00_0000, lnk.h_byte};
              cnt_next = 3'd1;
              st_next  = S_ADDR;
            end
            default: st_next = S_DONE;
          endcase
        end
      end
      S_ADDR:
      begin
        if (lnk.cs_n)
          st_next = S_IDLE;
        else if (fb)
        begin
          adr_next = {adr_reg[23:0], lnk.h_byte};
          cnt_next = cnt_reg + 3'd1;
          if (cnt_reg + 3'd1 == alen)
          begin
            av_next = 1'b1;
            st_next = S_DONE;
            if (alen == 3'd4)
              af_next = {adr_reg[23:0], lnk.h_byte};
            else if (!bank_reg[sfdpc_pkg::BANK_EXT_BIT])
              af_next = {1'b0, bank_reg[6:0], adr_reg[15:0], lnk.h_byte};
            else
              af_next = {8'h00, adr_reg[15:0], lnk.h_byte};
          end
        end
      end
      S_DATA:
      begin
        if (lnk.cs_n)
          st_next = S_IDLE;
        else if (lnk.d_ready && !rv_reg)
        begin
          rv_next = 1'b1;
          case (pidx_reg[1:0])
            2'd0:    rb_next = sfdpc_pkg::PARAM_WORD[7:0];
            2'd1:    rb_next = sfdpc_pkg::PARAM_WORD[15:8];
            2'd2:    rb_next = sfdpc_pkg::PARAM_WORD[23:16];
            default: rb_next = sfdpc_pkg::PARAM_WORD[31:24];
          endcase
          pidx_next = pidx_reg + 8'h01;
        end
      end
      S_DONE:
      begin
        if (lnk.cs_n)
          st_next = S_IDLE;
      end
      default: st_next = S_IDLE;
    endcase
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      st_reg   <= S_IDLE;
      op_reg   <= 8'h00;
      cnt_reg  <= 3'd0;
      adr_reg  <= 32'h0000_0000;
      a4_reg   <= 1'b0;
      bank_reg <= sfdpc_pkg::BANK_RST;
      vsr_reg  <= sfdpc_pkg::SR1_NV_RST;
      vact_reg <= 1'b0;    // sr1 follows the non-volatile copy
      wel_reg  <= 1'b0;
      vwel_reg <= 1'b0;
      ren_reg  <= 1'b0;
      rv_reg   <= 1'b0;
      rb_reg   <= 8'h00;
      av_reg   <= 1'b0;
      af_reg   <= 32'h0000_0000;
      rp_reg   <= 1'b0;
      pidx_reg <= 8'h00;
    end
    else
    begin
      st_reg   <= st_next;
      op_reg   <= op_next;
      cnt_reg  <= cnt_next;
      adr_reg  <= adr_next;
      a4_reg   <= a4_next;
      bank_reg <= bank_next;
      vsr_reg  <= vsr_next;
      vact_reg <= vact_next;
      wel_reg  <= wel_next;
      vwel_reg <= vwel_next;
      ren_reg  <= ren_next;
      rv_reg   <= rv_next;
      rb_reg   <= rb_next;
      av_reg   <= av_next;
      af_reg   <= af_next;
      rp_reg   <= rp_next;
      pidx_reg <= pidx_next;
    end
  end

  // non-volatile copy survives reset, as storage would
  always_ff @(posedge clk)
  begin
    nv_reg <= nv_next;
  end

  logic [7:0] sr1_reg;
  always_ff @(posedge clk)
  begin
    // reset drops the volatile copy, so sr1 shows storage at once
    if (srst)
      sr1_reg <= nv_next;
    else
      sr1_reg <= (vact_next ? vsr_next : nv_next);
  end

  assign lnk.d_valid = rv_reg;
  assign lnk.d_byte  = rb_reg;
  assign lnk.d_ready = 1'b1;
  assign addr4_mode  = a4_reg;
  assign bank        = bank_reg;
  assign sr1         = sr1_reg;
  assign sr1_nv      = nv_reg;
  assign sr1_vol     = vact_reg;
  assign addr_vld    = av_reg;
  assign addr_full   = af_reg;
  assign rst_pulse   = rp_reg;
endmodule

// >>> hdl/sfdpc_pkg.sv
// Purpose: shared constants for the addressing/reset command interpreter
// Assumes: one clock, commands delivered as whole bytes
// Notes:   opcodes, parameter word and field layout live here
package sfdpc_pkg;
  // ----------------------------------------------------------------
  // opcodes
  // ----------------------------------------------------------------
  localparam logic [7:0] OP_ENTER4    = 8'hB7;
  localparam logic [7:0] OP_BANK_RD   = 8'h16;
  localparam logic [7:0] OP_BANK_WR   = 8'h17;
  localparam logic [7:0] OP_RST_EN    = 8'h66;
  localparam logic [7:0] OP_RST       = 8'h99;
  localparam logic [7:0] OP_WREN      = 8'h06;
  localparam logic [7:0] OP_VWREN     = 8'h50;
  localparam logic [7:0] OP_SR1_WR    = 8'h01;
  localparam logic [7:0] OP_SR1_RD    = 8'h05;
  localparam logic [7:0] OP_PARAM_RD  = 8'h5A;
  // dedicated 4-byte opcodes differ from the plain ones in bit 4
  localparam int         OP4_FLAG_BIT = 4;
  localparam logic [7:0] OP_READ3     = 8'h03;
  localparam logic [7:0] OP_PROG3     = 8'h02;
  localparam logic [7:0] OP_READ4     = 8'h13;
  localparam logic [7:0] OP_PROG4     = 8'h12;
  // ----------------------------------------------------------------
  // parameter word and its fields
  // ----------------------------------------------------------------
  localparam logic [31:0] PARAM_WORD  = 32'hA1F8_60E8;
  localparam logic [7:0]  PARAM_BASE  = 8'h3C;
  localparam int ENTER_MSB = 31;
  localparam int ENTER_LSB = 24;
  localparam int EXIT_MSB  = 23;
  localparam int EXIT_LSB  = 14;
  localparam int RST_MSB   = 13;
  localparam int RST_LSB   = 8;
  localparam int RSVD_BIT  = 7;
  localparam int SRW_MSB   = 6;
  localparam int SRW_LSB   = 0;
  // ----------------------------------------------------------------
  // bank register layout and reset values
  // ----------------------------------------------------------------
  localparam int         BANK_EXT_BIT = 7;
  localparam logic [7:0] BANK_RST     = 8'h00;
  localparam logic [7:0] SR1_NV_RST   = 8'h00;
  // lane width codes: 1, 2 or 4 data lines
  localparam logic [1:0] LANES_1      = 2'h0;
  localparam logic [1:0] LANES_2      = 2'h1;
  localparam logic [1:0] LANES_4      = 2'h2;
endpackage

// >>> hdl/sfdpc_if.sv
// Purpose: byte-level command link between host and device ends
// Assumes: both ends on clk; one byte moves per valid/ready cycle
// Notes:   cs_n frames a command; first byte of a frame is the opcode
interface sfdpc_if;
  logic       cs_n;      // frame active low
  logic       h_valid;   // host byte valid
  logic [7:0] h_byte;    // host byte
  logic [1:0] h_lanes;   // lanes the host uses
  logic       d_valid;   // device reply byte valid
  logic [7:0] d_byte;    // device reply byte
  logic       d_ready;   // device can take a byte

  modport dev
  (
    input  cs_n,
    input  h_valid,
    input  h_byte,
    input  h_lanes,
    output d_valid,
    output d_byte,
    output d_ready
  );
  modport host
  (
    output cs_n,
    output h_valid,
    output h_byte,
    output h_lanes,
    input  d_valid,
    input  d_byte,
    input  d_ready
  );
endinterface

// >>> hdl/sfdpc_host.sv
// Purpose: host end: sends one command frame of up to five bytes
// Assumes: user holds cmd fields stable while busy
// Notes:   one byte per clock; reply byte captured when seen
module sfdpc_host
(
  input  wire logic       clk,      // system clock
  input  wire logic       srst,     // sync reset
  sfdpc_if.host           lnk,      // command link
  input  wire logic       go,       // start a frame pulse
  input  wire logic [2:0] nbytes,   // bytes in frame, 1..5
  input  wire logic [39:0] bytes,   // byte 0 in [7:0]
  input  wire logic [1:0] lanes,    // lane width to use
  output logic            busy,     // frame in progress
  output logic            rx_vld,   // reply byte pulse
  output logic [7:0]      rx_byte   // reply byte
);
  typedef enum {H_IDLE, H_SEND, H_END} sfdpc_hst_t;

  sfdpc_hst_t st_reg, st_next;
  logic [2:0] i_reg, i_next;
  logic       cs_reg, cs_next;
  logic       v_reg, v_next;
  logic [7:0] b_reg, b_next;
  logic [1:0] l_reg, l_next;
  logic       rv_reg, rv_next;
  logic [7:0] rb_reg, rb_next;

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb
  begin
    st_next = st_reg;
    i_next  = i_reg;
    cs_next = cs_reg;
    v_next  = 1'b0;
    b_next  = b_reg;
    l_next  = l_reg;
    rv_next = lnk.d_valid;
    rb_next = lnk.d_valid ? lnk.d_byte : rb_reg;
    case (st_reg)
      H_IDLE:
      begin
        if (go && nbytes != 3'd0)
        begin
          cs_next = 1'b0;
          v_next  = 1'b1;
          b_next  = bytes[7:0];
          l_next  = lanes;
          i_next  = 3'd1;
          st_next = H_SEND;
        end
      end
      H_SEND:
      begin
        if (i_reg == nbytes)
          st_next = H_END;
        else if (lnk.d_ready)
        begin
          v_next = 1'b1;
          b_next = bytes[8*i_reg +: 8];
          i_next = i_reg + 3'd1;
        end
      end
      H_END:
      begin
        // one idle cycle lets a reply land before the frame closes
        cs_next = 1'b1;
        st_next = H_IDLE;
      end
      default: st_next = H_IDLE;
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      st_reg <= H_IDLE;
      i_reg  <= 3'd0;
      cs_reg <= 1'b1;
      v_reg  <= 1'b0;
      b_reg  <= 8'h00;
      l_reg  <= 2'h0;
      rv_reg <= 1'b0;
      rb_reg <= 8'h00;
    end
    else
    begin
      st_reg <= st_next;
      i_reg  <= i_next;
      cs_reg <= cs_next;
      v_reg  <= v_next;
      b_reg  <= b_next;
      l_reg  <= l_next;
      rv_reg <= rv_next;
      rb_reg <= rb_next;
    end
  end

  assign lnk.cs_n    = cs_reg;
  assign lnk.h_valid = v_reg;
  assign lnk.h_byte  = b_reg;
  assign lnk.h_lanes = l_reg;
  assign busy        = (st_reg != H_IDLE);
  assign rx_vld      = rv_reg;
  assign rx_byte     = rb_reg;
endmodule

// >>> testbench/sfdpc_checker.sv
// Purpose: wire-level checks on the host/device command link
// Assumes: 05h, 16h and 5Ah are only sent on the device's own lane width
// Notes:   helper regs track opcode and byte index inside a frame
module sfdpc_checker
(
  input logic       clk,     // system clock
  input logic       srst,    // sync reset
  input logic       cs_n,    // frame active low
  input logic       h_valid, // host byte valid
  input logic [7:0] h_byte,  // host byte
  input logic [1:0] h_lanes, // host lane width
  input logic       d_valid, // reply byte valid
  input logic [7:0] d_byte,  // reply byte
  input logic       d_ready  // device ready
);
  timeunit 1ns;
  timeprecision 100ps;
  logic       take;
  logic [2:0] idx_reg;
  logic [7:0] op_reg;
  assign take = h_valid & ~cs_n;
  // ----------------------------------------------------------------
  // frame tracking
  // ----------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (srst | cs_n)
      idx_reg <= 3'h0;
    else if (take & (idx_reg != 3'h7))
      idx_reg <= idx_reg + 3'h1;
    if (srst)
      op_reg <= 8'h00;
    else if (take & (idx_reg == 3'h0))
      op_reg <= h_byte;
  end
  // ----------------------------------------------------------------
  // properties
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);
  chk_reply_single: assert property
    (d_valid && op_reg != 8'h5a |=> !d_valid)
    else $error("more than one reply byte");
  chk_bank_reply: assert property
    (take && idx_reg == 3'h0 && h_byte == 8'h16 |=> d_valid)
    else $error("no bank reply");
  chk_status_reply: assert property
    (take && idx_reg == 3'h0 && h_byte == 8'h05 |=> d_valid)
    else $error("no status reply");
  chk_param_first: assert property
    (take && idx_reg == 3'h1 && op_reg == 8'h5a && h_byte == 8'h3c
     |-> ##[1:2] (d_valid && d_byte == 8'he8))
    else $error("param byte 3c wrong");
  chk_param_next: assert property
    (d_valid && op_reg == 8'h5a && d_byte == 8'he8
     |-> ##2 (cs_n || (d_valid && d_byte == 8'h60)))
    else $error("param byte 3d wrong");
  chk_param_gap: assert property
    (d_valid && op_reg == 8'h5a |=> !d_valid)
    else $error("param bytes too close");
  chk_rst_quiet: assert property
    (take && idx_reg == 3'h0 && h_byte == 8'h99 |=> !d_valid)
    else $error("reply to reset");
  chk_idle_quiet: assert property
    (cs_n && $past(cs_n) |-> !d_valid)
    else $error("reply outside frame");
  chk_lanes_held: assert property
    (!cs_n && !$past(cs_n) |-> $stable(h_lanes))
    else $error("lanes changed in frame");
endmodule

// >>> testbench/tb_sfdpc.sv
// Purpose: drives the host end and checks the device end's state
// Assumes: byte frames of 1..5 bytes, four cs_n high cycles between
// Notes:   nv copy is written first since it powers up unknown
module tb_sfdpc;
  timeunit 1ns;
  timeprecision 100ps;
  logic        clk;
  logic        srst;
  logic        go;
  logic [2:0]  nbytes;
  logic [39:0] bytes;
  logic [1:0]  lanes;
  logic [1:0]  mode_lanes;
  logic        busy, rx_vld, addr4_mode, sr1_vol, addr_vld, rst_pulse;
  logic [7:0]  rx_byte, bank, sr1, sr1_nv;
  logic [31:0] addr_full, addr_cap;
  logic [7:0]  rxq[$];
  logic [31:0] pword = 32'ha1f8_60e8;
  int          num_errors = 0;
  int          n_tests = 0;
  int          n_rst = 0;
  sfdpc_if lnk();
  sfdpc_dev u_sfdpc_dev (.clk(clk), .srst(srst), .lnk(lnk),
    .mode_lanes(mode_lanes), .addr4_mode(addr4_mode), .bank(bank),
    .sr1(sr1), .sr1_nv(sr1_nv), .sr1_vol(sr1_vol), .addr_vld(addr_vld),
    .addr_full(addr_full), .rst_pulse(rst_pulse));
  sfdpc_host u_sfdpc_host (.clk(clk), .srst(srst), .lnk(lnk), .go(go),
    .nbytes(nbytes), .bytes(bytes), .lanes(lanes), .busy(busy),
    .rx_vld(rx_vld), .rx_byte(rx_byte));
  sfdpc_checker u_sfdpc_checker (.clk(clk), .srst(srst), .cs_n(lnk.cs_n),
    .h_valid(lnk.h_valid), .h_byte(lnk.h_byte), .h_lanes(lnk.h_lanes),
    .d_valid(lnk.d_valid), .d_byte(lnk.d_byte), .d_ready(lnk.d_ready));
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // ----------------------------------------------------------------
  // monitors
  // ----------------------------------------------------------------
  always @(posedge clk)
  begin
    if (rx_vld === 1'b1)
      rxq.push_back(rx_byte);
    if (addr_vld === 1'b1)
      addr_cap <= addr_full;
    if (rst_pulse === 1'b1)
      n_rst++;
  end
  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task automatic final_report();
    $display("checks %0d errors %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    n_tests++;
    if (g !== e)
    begin
      num_errors++;
      $display("MISMATCH %s exp %h got %h", nm, e, g);
    end
  endtask
  // one whole frame; bounded wait on busy
  task automatic send(input logic [2:0] n, input logic [39:0] b,
                      input logic [1:0] ln);
    int i;
    @(posedge clk);
    #1;
    go = 1'b1;
    nbytes = n;
    bytes = b;
    lanes = ln;
    @(posedge clk);
    #1;
    go = 1'b0;
    i = 0;
    while (busy !== 1'b0 && i < 50)
    begin
      @(posedge clk);
      #1;
      i++;
    end
    if (i >= 50)
    begin
      num_errors++;
      $display("MISMATCH busy exp 0 got %b", busy);
      final_report();
    end
    repeat (2) @(posedge clk);
    #1;
  endtask
  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial
  begin
    int nr;
    go = 1'b0;
    nbytes = 3'h1;
    bytes = 40'h00_0000_0000;
    lanes = 2'h0;
    mode_lanes = 2'h0;
    srst = 1'b1;
    repeat (16) @(posedge clk);
    #1;
    srst = 1'b0;
    chk("mode", 1'h0, addr4_mode);
    send(3'h1, 40'h00_0000_0006, 2'h0);
    send(3'h2, 40'h00_0000_a501, 2'h0);
    chk("sr1_nv", 8'ha5, sr1_nv);
    send(3'h2, 40'h00_0000_3c01, 2'h0);
    chk("sr1_nv", 8'ha5, sr1_nv);
    // wrong width must leave the mode alone
    send(3'h1, 40'h00_0000_00b7, 2'h1);
    chk("mode", 1'h0, addr4_mode);
    send(3'h2, 40'h00_0000_8517, 2'h0);
    chk("bank", 8'h85, bank);
    rxq.delete();
    send(3'h1, 40'h00_0000_0016, 2'h0);
    chk("bank_rd", 8'h85, rxq[0]);
    send(3'h5, 40'h78_5634_1213, 2'h0);
    chk("addr", 32'h1234_5678, addr_cap);
    send(3'h1, 40'h00_0000_00b7, 2'h0);
    chk("mode", 1'h1, addr4_mode);
    send(3'h5, 40'h0d_0c0b_0a12, 2'h0);
    chk("addr", 32'h0a0b_0c0d, addr_cap);
    for (int k = 0; k < 4; k++)
    begin
      rxq.delete();
      send(3'h5, {24'h00_0000, 8'h3c + 8'(k), 8'h5a}, 2'h0);
      chk("param0", pword[8*k +: 8], rxq[0]);
      chk("param1", pword[8*((k+1)%4) +: 8], rxq[1]);
    end
    for (int k = 0; k < 3; k++)
    begin
      mode_lanes = 2'(k);
      send(3'h2, 40'h00_0000_4217, 2'(k));
      send(3'h1, 40'h00_0000_00b7, 2'(k));
      nr = n_rst;
      send(3'h1, 40'h00_0000_0099, 2'(k));
      chk("rst_cnt", nr, n_rst);
      chk("bank", 8'h42, bank);
      send(3'h1, 40'h00_0000_0066, 2'(k));
      send(3'h1, 40'h00_0000_0099, 2'(k));
      chk("rst_cnt", nr + 1, n_rst);
      chk("mode", 1'h0, addr4_mode);
      chk("bank", 8'h00, bank);
    end
    mode_lanes = 2'h0;
    // another command between the pair breaks it
    nr = n_rst;
    send(3'h1, 40'h00_0000_0066, 2'h0);
    send(3'h1, 40'h00_0000_0005, 2'h0);
    send(3'h1, 40'h00_0000_0099, 2'h0);
    chk("rst_cnt", nr, n_rst);
    // plain opcode: 3-byte address, bank gives the top bits
    send(3'h2, 40'h00_0000_4217, 2'h0);
    send(3'h4, 40'h00_5634_1203, 2'h0);
    chk("addr", 32'h4212_3456, addr_cap);
    send(3'h1, 40'h00_0000_00b7, 2'h0);
    send(3'h5, 40'h78_5634_1203, 2'h0);
    chk("addr", 32'h1234_5678, addr_cap);
    send(3'h1, 40'h00_0000_0050, 2'h0);
    chk("vol", 1'h1, sr1_vol);
    send(3'h2, 40'h00_0000_3c01, 2'h0);
    chk("sr1", 8'h3c, sr1);
    chk("sr1_nv", 8'ha5, sr1_nv);
    // power-up stand-in: volatile copy is lost
    @(posedge clk);
    #1;
    srst = 1'b1;
    @(posedge clk);
    #1;
    chk("sr1", 8'ha5, sr1);
    srst = 1'b0;
    @(posedge clk);
    #1;
    chk("sr1", 8'ha5, sr1);
    chk("vol", 1'h0, sr1_vol);
    chk("mode", 1'h0, addr4_mode);
    final_report();
  end
endmodule
